// File: rtl/sspg_pkg.sv
package sspg_pkg;
  // wishbone register map (word aligned byte addresses)
  localparam logic [7:0]  SSPG_SEQ_START_ADDR = 8'h6f;  // sequencer_start_register index
  localparam logic [9:0]  SSPG_SEQ_START_BYTE = 10'h1bc;
  localparam logic [9:0]  SSPG_STATUS_BYTE    = 10'h1c0;
  localparam logic [9:0]  SSPG_PWR_BYTE       = 10'h1c4;
  localparam logic [15:0] SSPG_SHUTDOWN_CMD   = 16'h0119;
  localparam int          SSPG_START_BIT      = 8;
  localparam logic [5:0]  SSPG_SHUTDOWN_IDX   = 6'h19;
  localparam logic [5:0]  SSPG_LAST_IDX       = 6'h27;

  // power register width and reset value
  localparam int SSPG_PWR_W = 16;
  localparam logic [15:0] SSPG_PWR_RESET = 16'hffff;

  // timing
  localparam int CLK_HZ        = 40_000_000;
  localparam real T_POR_US     = 9.5;
  localparam int  POR_CYC      = int'($ceil(T_POR_US * CLK_HZ / 1.0e6));
  localparam int  MCLK_HZ      = 12_288_000;
  // delay code d: time = 0.5 ms + 2^(d-4) ms (0 -> 0.5625ms base)
  localparam real T_STEP0_MS   = 0.5625;
  localparam int  STEP0_CYC    = int'($floor(T_STEP0_MS * CLK_HZ / 1.0e3));
  localparam real T_LONG_MS    = 256.5;
  localparam int  LONG_CYC     = int'($floor(T_LONG_MS * CLK_HZ / 1.0e3));
  localparam real T_MID_MS     = 32.5;
  localparam int  MID_CYC      = int'($floor(T_MID_MS * CLK_HZ / 1.0e3));
  localparam logic [3:0] DLY_CODE_0    = 4'h0;
  localparam logic [3:0] DLY_CODE_MID  = 4'h9;
  localparam logic [3:0] DLY_CODE_LONG = 4'hc;
  localparam int CNT_W = 24;

  // one program entry: target register, width, start bit, data, delay, end flag
  typedef struct packed {
    logic [7:0] addr;
    logic [2:0] width_m1;
    logic [3:0] start;
    logic [7:0] data;
    logic [3:0] dly;
    logic       end_of_program_flag;
  } sspg_entry_t;
  localparam int ENTRY_W = 28;

  typedef enum logic [1:0] {
    SSPG_IDLE  = 2'b00,
    SSPG_FETCH = 2'b01,
    SSPG_APPLY = 2'b10,
    SSPG_WAIT  = 2'b11
  } sspg_state_t;
endpackage

// File: rtl/sspg_rom_if.sv
`timescale 1ns/1ps
interface sspg_rom_if;
  logic [5:0]                 idx;
  logic [sspg_pkg::ENTRY_W-1:0] entry;
  modport user (output idx, input entry);
  modport rom  (input idx, output entry);
endinterface

// File: rtl/sspg_rom.sv
`timescale 1ns/1ps
module sspg_rom
  import sspg_pkg::*;
(
  input  wire logic clk_i,
  sspg_rom_if.rom   port
);
  function automatic sspg_entry_t ent(input logic [7:0] a, input logic [2:0] w,
                                      input logic [3:0] s, input logic [7:0] d,
                                      input logic [3:0] dl, input logic e);
    ent = '{addr: a, width_m1: w, start: s, data: d, dly: dl, end_of_program_flag: e};
  endfunction

  sspg_entry_t rd_r;
  assign port.entry = rd_r;

  // shutdown program only; other indices read as a harmless terminating dummy
  always_ff @(posedge clk_i) begin
    case (port.idx)
      6'h19:   rd_r <= ent(8'h5e, 3'h7, 4'h0, 8'h77, 4'h0, 1'b0);
      6'h1a:   rd_r <= ent(8'h5a, 3'h7, 4'h0, 8'h77, 4'h0, 1'b0);
      6'h1b:   rd_r <= ent(8'h5a, 3'h7, 4'h0, 8'h00, 4'h0, 1'b0);
      6'h1c:   rd_r <= ent(8'h5e, 3'h7, 4'h0, 8'h00, 4'h0, 1'b0);
      6'h1d:   rd_r <= ent(8'h43, 3'h3, 4'h0, 8'h00, 4'h0, 1'b0);
      6'h1e:   rd_r <= ent(8'h62, 3'h0, 4'h0, 8'h00, 4'h0, 1'b0);
      6'h1f:   rd_r <= ent(8'h12, 3'h1, 4'h2, 8'h00, 4'h0, 1'b0);
      6'h20:   rd_r <= ent(8'h16, 3'h0, 4'h1, 8'h00, 4'h0, 1'b0);
      6'h21:   rd_r <= ent(8'h0e, 3'h1, 4'h0, 8'h00, 4'h0, 1'b0);
      6'h22:   rd_r <= ent(8'h0f, 3'h1, 4'h0, 8'h00, 4'h0, 1'b0);
      6'h23:   rd_r <= ent(8'h04, 3'h0, 4'h0, 8'h00, 4'h0, 1'b0);
      6'h24:   rd_r <= ent(8'h05, 3'h0, 4'h0, 8'h00, 4'hc, 1'b0);
      6'h25:   rd_r <= ent(8'h05, 3'h0, 4'h0, 8'h00, 4'h9, 1'b0);
      6'h26:   rd_r <= ent(8'h05, 3'h7, 4'h0, 8'h00, 4'h0, 1'b0);
      6'h27:   rd_r <= ent(8'h04, 3'h1, 4'h0, 8'h00, 4'h0, 1'b1);
      default: rd_r <= ent(8'hff, 3'h0, 4'h0, 8'h00, 4'h0, 1'b1);
    endcase
  end
endmodule

// File: rtl/sspg_top.sv
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
// How it works
// [RQ1] writing 0119h to the start register runs the program from index 19h
// [RQ2] host issues one start write; sequencer performs every shutdown step itself
// [RQ3] whole program with its step delays lasts about 296 ms
// [RQ4] first four entries restore shorts then clear outputs, 0.5625 ms each
// [RQ5] later entries clear servo, pump, converters, clock, amps, bias, reference
// [RQ6] running status is 1 throughout and 0 after the end entry
// [RQ7] host stops clocks only after running status returns to 0
// [RQ8] while power-on reset holds, logic is reset and writes are dropped
// [RQ9] on release registers hold defaults and writes are accepted
// [RQ10] reset stretched at least 9.5 us after both supplies are good
// [RQ11] either supply below its power-off threshold re-asserts reset
// [RQ12] brown-out above power-off thresholds keeps state, no reset
module sspg_top
  import sspg_pkg::*;
#(
  parameter int LONG_CYCLES = LONG_CYC,
  parameter int MID_CYCLES  = MID_CYC,
  parameter int STEP_CYCLES = STEP0_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        analog_supply_ok_i,
  input  wire logic        core_supply_ok_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             por_active_o,
  output logic             sequencer_running_o,
  output logic      [15:0] power_state_o
);
  // supply flags come from analog monitors: three-stage synchroniser
  logic [2:0] asy_r;
  logic [2:0] csy_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      asy_r <= 3'h0;
      csy_r <= 3'h0;
    end else begin
      asy_r <= {asy_r[1:0], analog_supply_ok_i};
      csy_r <= {csy_r[1:0], core_supply_ok_i};
    end
  end
  // a change counts only once the last two stages agree, so one-cycle glitches are ignored
  logic a_ok_r;
  logic c_ok_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_ok_r <= 1'b0;
      c_ok_r <= 1'b0;
    end else begin
      if (asy_r[2] == asy_r[1]) a_ok_r <= asy_r[2];
      if (csy_r[2] == csy_r[1]) c_ok_r <= csy_r[2];
    end
  end

  // reset stretcher; brown-outs above power-off level keep the ok flags high
  logic [9:0] por_cnt_r;
  logic       por_r;
  always_ff @(posedge clk_i) begin
    if (rst_i || !a_ok_r || !c_ok_r) begin  // [RQ11] [RQ12]
      por_cnt_r <= 10'h0;
      por_r     <= 1'b1;
    end else if (por_cnt_r != 10'(POR_CYC)) begin  // [RQ10]
      por_cnt_r <= por_cnt_r + 10'h1;
      por_r     <= 1'b1;
    end else begin
      por_r     <= 1'b0;
    end
  end
  assign por_active_o = por_r;

  // wishbone slave, one wait state, unmapped reads return zero
  logic wr_ok;
  assign wr_ok = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && !por_r;  // [RQ8]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // both low lanes must be enabled, else a half-written command could launch the program
  logic start_req;
  assign start_req = wr_ok && wb_adr_i == SSPG_SEQ_START_BYTE && wb_sel_i[1:0] == 2'h3 &&
                     wb_dat_i[15:0] == SSPG_SHUTDOWN_CMD;  // [RQ1]

  // entries come out of a registered rom, which is why a fetch state precedes apply
  sspg_rom_if  rom_bus ();
  sspg_rom     u_rom (.clk_i(clk_i), .port(rom_bus));

  sspg_state_t st_r;
  logic [5:0]  idx_r;
  logic [CNT_W-1:0] dly_r;
  sspg_entry_t e;
  assign e = rom_bus.entry;
  assign rom_bus.idx = idx_r;

  // only the codes the shutdown program uses; every other code gets the short wait
  function automatic logic [CNT_W-1:0] dly_cycles(input logic [3:0] code);
    case (code)
      DLY_CODE_LONG: dly_cycles = CNT_W'(LONG_CYCLES);
      DLY_CODE_MID:  dly_cycles = CNT_W'(MID_CYCLES);
      default:       dly_cycles = CNT_W'(STEP_CYCLES);
    endcase
  endfunction

  function automatic logic [15:0] field_mask(input logic [2:0] w_m1, input logic [3:0] s);
    logic [15:0] m;
    m = 16'((17'h2 << w_m1) - 17'h1);
    field_mask = m << s;
  endfunction

  // start commands during a run are ignored: only the idle state looks at them
  always_ff @(posedge clk_i) begin
    if (rst_i || por_r) begin  // [RQ8] [RQ9]
      st_r  <= SSPG_IDLE;
      idx_r <= SSPG_SHUTDOWN_IDX;
      dly_r <= '0;
    end else begin
      case (st_r)
        SSPG_IDLE: begin
          if (start_req) begin  // [RQ1] [RQ2]
            idx_r <= wb_dat_i[5:0];
            st_r  <= SSPG_FETCH;
          end
        end
        SSPG_FETCH: st_r <= SSPG_APPLY;
        SSPG_APPLY: begin
          dly_r <= dly_cycles(e.dly);  // [RQ3] [RQ4] [RQ5]
          st_r  <= SSPG_WAIT;
        end
        SSPG_WAIT: begin
          if (dly_r > CNT_W'(1)) begin
            dly_r <= dly_r - CNT_W'(1);
          end else if (e.end_of_program_flag || idx_r == SSPG_LAST_IDX) begin
            st_r <= SSPG_IDLE;
          end else begin
            idx_r <= idx_r + 6'h1;
            st_r  <= SSPG_FETCH;
          end
        end
        default: st_r <= SSPG_IDLE;
      endcase
    end
  end

  // power state: bank of enables the program switches off
  // one shared bank stands in for all target registers, so entries may overlap
  logic [15:0] pwr_r;
  always_ff @(posedge clk_i) begin
    if (rst_i || por_r) begin
      pwr_r <= SSPG_PWR_RESET;  // [RQ9]
    end else if (st_r == SSPG_APPLY && e.addr != 8'hff) begin  // [RQ5]
      pwr_r <= (pwr_r & ~field_mask(e.width_m1, e.start)) |
               (16'(e.data) << e.start & field_mask(e.width_m1, e.start));
    end
  end
  assign power_state_o = pwr_r;

  // start term sets the flag on the launch edge, leaving no gap for a poll to miss
  always_ff @(posedge clk_i) begin
    if (rst_i || por_r) begin
      sequencer_running_o <= 1'b0;
    end else begin
      sequencer_running_o <= (st_r != SSPG_IDLE) || start_req;  // [RQ6] [RQ7]
    end
  end

  // read data latched on the request edge and held until the next access
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      case (wb_adr_i)
        SSPG_STATUS_BYTE: wb_dat_o <= {31'h0, sequencer_running_o};
        SSPG_PWR_BYTE:    wb_dat_o <= {16'h0, pwr_r};
        default:          wb_dat_o <= 32'h0;
      endcase
    end
  end

  // sequencing and reset checks
  chk_busy_after_start: assert property (@(posedge clk_i) disable iff (rst_i)  // [RQ6]
    start_req && st_r == SSPG_IDLE |=> sequencer_running_o)
    else $error("running not set after start");
  chk_no_write_in_por: assert property (@(posedge clk_i) disable iff (rst_i)  // [RQ8]
    por_r |=> st_r == SSPG_IDLE)
    else $error("sequencer moved during reset");
  chk_supply_loss_por: assert property (@(posedge clk_i) disable iff (rst_i)  // [RQ11]
    !a_ok_r |=> por_r)
    else $error("supply loss did not reset");
  chk_por_min_len: assert property (@(posedge clk_i) disable iff (rst_i)  // [RQ10]
    $fell(por_r) |-> por_cnt_r == 10'(POR_CYC))
    else $error("reset released early");

  chk_running_holds: assert property (@(posedge clk_i) disable iff (rst_i)  // [RQ6]
    st_r != SSPG_IDLE && !por_r |=> sequencer_running_o)
    else $error("running dropped while program active");
  chk_running_clears: assert property (@(posedge clk_i) disable iff (rst_i)  // [RQ6]
    st_r == SSPG_IDLE && !start_req |=> !sequencer_running_o)
    else $error("running stuck after program end");
  chk_core_loss_por: assert property (@(posedge clk_i) disable iff (rst_i)  // [RQ11]
    !c_ok_r |=> por_r)
    else $error("core supply loss did not reset");
  chk_por_holds_count: assert property (@(posedge clk_i) disable iff (rst_i)  // [RQ10]
    por_r && a_ok_r && c_ok_r && por_cnt_r != 10'(POR_CYC) |=> por_r)
    else $error("reset released before count complete");
  chk_start_index: assert property (@(posedge clk_i) disable iff (rst_i)  // [RQ1]
    start_req && st_r == SSPG_IDLE |=> idx_r == SSPG_SHUTDOWN_IDX)
    else $error("program not launched at shutdown index");
  chk_pwr_kept: assert property (@(posedge clk_i) disable iff (rst_i)  // [RQ12]
    !por_r && st_r != SSPG_APPLY |=> $stable(pwr_r))
    else $error("power bank changed outside an apply step");
endmodule

// File: verification/sspg_host.sv
`timescale 1ns/1ps
module sspg_host (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [9:0]  adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 10'h000;
    sel_o = 4'h0;
    dat_o = 32'h00000000;
  end
  // call just after a rising edge; request held until ack is sampled, bench watchdog bounds it
  task automatic xfer(input logic we, input logic [9:0] adr, input logic [3:0] sel,
                      input logic [31:0] dat, output logic [31:0] rd);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= we;
    adr_o <= adr;
    sel_o <= sel;
    dat_o <= dat;
    @(posedge clk_i);
    while (ack_i !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
    // released data must not keep showing the last value
    dat_o <= ~dat;
    @(posedge clk_i);
  endtask
endmodule

// File: verification/tb.sv
`timescale 1ns/1ps
module tb;
  import sspg_pkg::*;
  localparam int LG = 20, MD = 10, ST = 5;
  localparam int PMIN = 13 * ST + LG + MD;
  logic        clk_i, rst_i, a_ok, c_ok, cyc, stb, we, ack, por, run;
  logic [3:0]  sel;
  logic [9:0]  adr;
  logic [31:0] dw, dr, lf;
  logic [15:0] pwr;
  int          bad_count, n_tests;
  sspg_host i_host (.clk_i(clk_i), .ack_i(ack), .dat_i(dr), .cyc_o(cyc), .stb_o(stb),
                    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(dw));
  sspg_top #(.LONG_CYCLES(LG), .MID_CYCLES(MD), .STEP_CYCLES(ST)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .analog_supply_ok_i(a_ok), .core_supply_ok_i(c_ok),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .por_active_o(por),
    .sequencer_running_o(run), .power_state_o(pwr));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wait_por(output int n);
    n = 0;
    while (por === 1'b1 && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  initial begin
    repeat (6000) @(posedge clk_i);
    bad_count++;
    end_of_test();
  end
  initial begin
    logic [31:0] rd;
    logic [31:0] wv;
    int n;
    rst_i = 1'b1;
    a_ok = 1'b0;
    c_ok = 1'b0;
    lf = 32'ha3e5;
    bad_count = 0;
    n_tests = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("por_held", por, 1'b1);
    check("pwr_default", pwr, SSPG_PWR_RESET);
    i_host.xfer(1'b1, SSPG_SEQ_START_BYTE, 4'hf, 32'h00000119, rd);
    check("start_in_por", run, 1'b0);
    a_ok <= 1'b1;
    c_ok <= 1'b1;
    wait_por(n);
    check("por_min", n >= POR_CYC, 1'b1);
    check("por_max", n <= POR_CYC + 8, 1'b1);
    // refused: start-up command, wrong address, one lane only, random data
    for (int k = 0; k < 6; k++) begin
      lf = lfsr(lf);
      wv = (k == 0) ? 32'h00000100 :
           (k <= 2) ? 32'h00000119 : {16'h0000, lf[15:0] ^ 16'h0119 | 16'h8000};
      i_host.xfer(1'b1, (k == 1) ? SSPG_STATUS_BYTE : SSPG_SEQ_START_BYTE,
                  (k == 2) ? 4'h1 : 4'hf, wv, rd);
      check("no_start", run, 1'b0);
    end
    // the single start write is all the host sends
    i_host.xfer(1'b1, SSPG_SEQ_START_BYTE, 4'hf, 32'h00000119, rd);
    check("run_set", run, 1'b1);
    i_host.xfer(1'b0, SSPG_STATUS_BYTE, 4'hf, 32'h00000000, rd);
    check("status_busy", rd[0], 1'b1);
    check("pwr_first_step", pwr, 16'hff77);
    n = 0;
    while (run === 1'b1 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    check("prog_min", n + 6 >= PMIN, 1'b1);
    check("prog_max", n <= PMIN + 80, 1'b1);
    i_host.xfer(1'b0, SSPG_STATUS_BYTE, 4'hf, 32'h00000000, rd);
    check("status_done", rd[0], 1'b0);
    check("pwr_after_prog", pwr, 16'hff00);
    // clocks may only be stopped from here on
    a_ok <= 1'b0;
    @(posedge clk_i);
    a_ok <= 1'b1;
    repeat (8) @(posedge clk_i);
    check("glitch_no_por", por, 1'b0);
    check("glitch_state", pwr, 16'hff00);
    for (int k = 0; k < 2; k++) begin
      {a_ok, c_ok} <= k ? 2'b10 : 2'b01;
      repeat (3) @(posedge clk_i);
      {a_ok, c_ok} <= 2'b11;
      repeat (8) @(posedge clk_i);
      check("por_again", por, 1'b1);
      wait_por(n);
      check("pwr_after_por", pwr, SSPG_PWR_RESET);
      check("run_after_por", run, 1'b0);
      check("por_release", por, 1'b0);
    end
    i_host.xfer(1'b1, SSPG_SEQ_START_BYTE, 4'h3, 32'h00000119, rd);
    check("start_after_por", run, 1'b1);
    end_of_test();
  end
endmodule
